// file: spp_params.svh
// offsets, field positions and timing counts of the serial port
// assumes a byte-addressed register bus with one 32-bit word per register
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

// ==========================================================
// register byte offsets
`define SPP_OFF_DATA 8'h00
`define SPP_OFF_CTRL 8'h04
`define SPP_OFF_STAT 8'h08
`define SPP_OFF_IRQC 8'h0c

// ==========================================================
// field positions
`define SPP_CTRL_WRITE_COLLISION 7
`define SPP_CTRL_SOV 6
`define SPP_CTRL_EN 5
`define SPP_CTRL_CKP 4
`define SPP_STAT_SMP 7
`define SPP_STAT_CKE 6
`define SPP_STAT_BF 0
`define SPP_IRQC_FLAG 0
`define SPP_IRQC_IEN 1
`define SPP_IRQC_TXDIS 2

// ==========================================================
// timing: system clocks per serial bit for the three divided rates
`define SPP_BIT_CLKS_DIV4 4
`define SPP_BIT_CLKS_DIV16 16
`define SPP_BIT_CLKS_DIV64 64

// ==========================================================
// bus answers
`define SPP_RESP_OKAY 2'b00
`define SPP_RESP_SLVERR 2'b10

`endif

// file: spp_pkg.sv
// types shared by the serial port
// assumes spp_params.svh is compiled alongside
package spp_pkg;

    // ==========================================================
    // mode codes of the control register
    typedef enum logic [3:0] {
        SPP_M_DIV4 = 4'h0,
        SPP_M_DIV16 = 4'h1,
        SPP_M_DIV64 = 4'h2,
        SPP_M_TMR = 4'h3,
        SPP_M_SLV_SS = 4'h4,
        SPP_M_SLV_NOSS = 4'h5
    } spp_mode_t;

    // master transfer sequencer
    typedef enum logic [0:0] {
        SPP_IDLE = 1'b0,
        SPP_RUN = 1'b1
    } spp_state_t;

endpackage

// file: spp_port.sv
// synchronous serial port, spi role, with an axi4-lite register slave
// assumes serial pins already sampled in core_clk terms; pad logic resolves oe
//
// Behaviour
// - port works only while port_enable is set; setting it hands pins over
// - serial clock pin driven in master role, input in slave role
// - data leaves on one clock edge; the slave, and the master with sample_phase clear, capture on the opposite one
// - master write to data buffer starts an 8-bit exchange at once
// - with data output disabled, bytes still arrive with normal status
// - most significant bit goes out first
// - master rate is clock over 4, 16, 64, or half the timer rate
// - master clock idles at the polarity level
// - with edge select set, first data bit is valid before first edge
// - sample_phase picks middle or end of bit for master sampling
// - slave shifts on external clock; flag rises after the last bit
// - slave keeps shifting during sleep; byte end flags, and wakes if port interrupts are enabled
// - select-controlled slave with select low exchanges and drives output
// - select high floats data output, even mid byte
// - select high in mode 4 or port disable zeroes the bit counter
// - master freezes during sleep and resumes where it stopped
// - byte end wakes the device only if port interrupts are enabled
// - reset disables the port and aborts any transfer
// - spi modes map to polarity and edge bits as the mode table
// - a complete byte sets the flag and is copied to the buffer, except in slave role with buffer_full set (then sov is set)
// - buffer write during a transfer is dropped and sets write_collision
// - reading the data buffer clears buffer_full
`timescale 1ns/1ns
`default_nettype none
`include "spp_params.svh"

module spp_port
    import spp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic sleep_mode,
    input wire logic timer_tick,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe,
    input wire logic sdi,
    output logic sdo_out,
    output logic sdo_oe,
    input wire logic ss_n,
    output logic wake_req
);

    // ==========================================================
    // state
    typedef struct packed {
        spp_state_t mstate;
        logic awready;
        logic wready;
        logic aw_full;
        logic w_full;
        logic [7:0] aw_addr;
        logic [7:0] wdata;
        logic wstrb0;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] data_buf;
        logic write_collision;
        logic sov;
        logic en;
        logic clock_polarity;
        logic [3:0] mode;
        logic sample_phase;
        logic cke;
        logic bf;
        logic irq_flag;
        logic irq_en;
        logic tx_dis;
        logic [7:0] tx_sr;
        logic [7:0] rx_sr;
        logic txbit;
        logic [4:0] half;
        logic [5:0] div;
        logic [3:0] bitcnt;
        logic sck_out;
        logic sck_oe;
        logic sdo_oe;
        logic wake;
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic ss_s1;
        logic ss_s2;
    } spp_state_s_t;

    spp_state_s_t s;
    spp_state_s_t next_s;

    // address decode shared by read and write paths; 4 means unmapped
    function automatic logic [2:0] spp_decode(input logic [7:0] a);
        if (a == `SPP_OFF_DATA)
            spp_decode = 3'h0;
        else if (a == `SPP_OFF_CTRL)
            spp_decode = 3'h1;
        else if (a == `SPP_OFF_STAT)
            spp_decode = 3'h2;
        else if (a == `SPP_OFF_IRQC)
            spp_decode = 3'h3;
        else
            spp_decode = 3'h4;
    endfunction

    // ==========================================================
    // helper terms
    logic is_master;
    logic is_slave;
    logic slave_live;
    logic busy;
    logic wr_commit;
    logic data_wr;
    logic data_rd;
    logic m_tick;
    logic m_tx;
    logic m_smp;
    logic m_last;
    logic s_lead;
    logic s_trail;
    logic s_tx;
    logic s_smp;
    logic deliver;
    logic [7:0] rx_new;
    logic [5:0] half_clks;
    logic [4:0] last_half;

    assign is_master = s.mode < 4'(SPP_M_SLV_SS);
    assign is_slave = (s.mode == SPP_M_SLV_SS) || (s.mode == SPP_M_SLV_NOSS);
    // select gates the slave only in mode 4
    assign slave_live = s.en && is_slave && ((s.mode == SPP_M_SLV_NOSS) || !s.ss_s2);
    assign busy = (s.mstate == SPP_RUN) || (is_slave && s.bitcnt != 4'h0);
    assign wr_commit = s.aw_full && s.w_full && !s.bvalid;
    assign data_wr = wr_commit && s.wstrb0 && (spp_decode(s.aw_addr) == 3'h0);
    assign data_rd = s_axi_arvalid && s.arready && (spp_decode(s_axi_araddr) == 3'h0);

    // master rate: half a bit per divider wrap, or one timer tick
    always_comb
    begin
        case (s.mode)
            SPP_M_DIV16: half_clks = 6'(`SPP_BIT_CLKS_DIV16 / 2);
            SPP_M_DIV64: half_clks = 6'(`SPP_BIT_CLKS_DIV64 / 2);
            default: half_clks = 6'(`SPP_BIT_CLKS_DIV4 / 2);
        endcase
    end

    // sleep halts the master sequencer where it stands
    assign m_tick = (s.mstate == SPP_RUN) && !sleep_mode
        && ((s.mode == SPP_M_TMR) ? timer_tick : (s.div == half_clks - 6'd1));
    // edge 0 is idle to active; even edges lead, odd edges trail
    assign last_half = (!s.cke && s.sample_phase) ? 5'd16 : 5'd15;
    assign m_tx = s.cke ? (s.half[0] && s.half < 5'd15)
        : (!s.half[0] && s.half < 5'd16);
    // sample at mid bit, or at the end of the bit when sample_phase is set
    assign m_smp = s.sample_phase ? ((s.half[0] == s.cke) && (s.cke || s.half != 5'd0))
        : (s.half[0] != s.cke);
    assign m_last = s.half == last_half;

    // slave edges from the synchronised clock; stage one is never read here
    assign s_lead = (s.sck_s2 != s.clock_polarity) && (s.sck_s3 == s.clock_polarity);
    assign s_trail = (s.sck_s2 == s.clock_polarity) && (s.sck_s3 != s.clock_polarity);
    // trailing-edge shifts wait for a byte in flight so a fresh load is kept
    assign s_tx = slave_live && (s.cke ? (s_trail && s.bitcnt != 4'h0) : s_lead);
    assign s_smp = slave_live && (s.cke ? s_lead : s_trail);

    assign rx_new = {s.rx_sr[6:0], sdi};
    assign deliver = (m_tick && m_last) || (s_smp && s.bitcnt == 4'h7);

    // ==========================================================
    // next state
    always_comb
    begin
        next_s = s;
        next_s.sck_s1 = sck_in;
        next_s.sck_s2 = s.sck_s1;
        next_s.sck_s3 = s.sck_s2;
        next_s.ss_s1 = ss_n;
        next_s.ss_s2 = s.ss_s1;

        // bus: address and data taken in either order
        if (s_axi_awvalid && s.awready)
        begin
            next_s.aw_full = 1'b1;
            next_s.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s.wready)
        begin
            next_s.w_full = 1'b1;
            next_s.wdata = s_axi_wdata[7:0];
            next_s.wstrb0 = s_axi_wstrb[0];
        end
        if (s.bvalid && s_axi_bready)
            next_s.bvalid = 1'b0;
        if (s.rvalid && s_axi_rready)
            next_s.rvalid = 1'b0;

        // read: upper bits and reserved fields read as zero
        if (s_axi_arvalid && s.arready)
        begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `SPP_RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            case (spp_decode(s_axi_araddr))
                3'h0: next_s.rdata[7:0] = s.data_buf;
                3'h1: next_s.rdata[7:0] = {s.write_collision, s.sov, s.en, s.clock_polarity, s.mode};
                3'h2: next_s.rdata[7:0] = {s.sample_phase, s.cke, 5'h00, s.bf};
                3'h3: next_s.rdata[2:0] = {s.tx_dis, s.irq_en, s.irq_flag};
                default: next_s.rresp = `SPP_RESP_SLVERR;
            endcase
        end
        if (data_rd)
            next_s.bf = 1'b0;

        // write commit once both halves are held
        if (wr_commit)
        begin
            next_s.aw_full = 1'b0;
            next_s.w_full = 1'b0;
            next_s.bvalid = 1'b1;
            next_s.bresp = (spp_decode(s.aw_addr) == 3'h4) ? `SPP_RESP_SLVERR
                : `SPP_RESP_OKAY;
            if (s.wstrb0)
            begin
                if (spp_decode(s.aw_addr) == 3'h1)
                begin
                    next_s.write_collision = s.wdata[`SPP_CTRL_WRITE_COLLISION];
                    next_s.sov = s.wdata[`SPP_CTRL_SOV];
                    next_s.en = s.wdata[`SPP_CTRL_EN];
                    next_s.clock_polarity = s.wdata[`SPP_CTRL_CKP];
                    next_s.mode = s.wdata[3:0];
                end
                else if (spp_decode(s.aw_addr) == 3'h2)
                begin
                    next_s.sample_phase = s.wdata[`SPP_STAT_SMP];
                    next_s.cke = s.wdata[`SPP_STAT_CKE];
                end
                else if (spp_decode(s.aw_addr) == 3'h3)
                begin
                    if (s.wdata[`SPP_IRQC_FLAG])
                        next_s.irq_flag = 1'b0;
                    next_s.irq_en = s.wdata[`SPP_IRQC_IEN];
                    next_s.tx_dis = s.wdata[`SPP_IRQC_TXDIS];
                end
            end
        end

        // data buffer write: dropped while a byte is moving
        if (data_wr)
        begin
            if (busy)
                next_s.write_collision = 1'b1;
            else
            begin
                next_s.data_buf = s.wdata;
                next_s.tx_sr = s.wdata;
                next_s.txbit = s.wdata[7];
                // with edge select set, bit 7 already stands on the line, so both roles skip it
                if (s.cke)
                    next_s.tx_sr = {s.wdata[6:0], 1'b0};
                if (s.en && is_master)
                begin
                    next_s.mstate = SPP_RUN;
                    next_s.half = 5'd0;
                    next_s.div = 6'd0;
                end
            end
        end

        // master sequencer
        if (s.mstate == SPP_RUN && !sleep_mode)
            next_s.div = m_tick ? 6'd0 : s.div + 6'd1;
        if (m_tick)
        begin
            next_s.half = s.half + 5'd1;
            if (s.half < 5'd16)
                next_s.sck_out = ~s.sck_out;
            if (m_tx)
            begin
                next_s.txbit = s.tx_sr[7];
                next_s.tx_sr = {s.tx_sr[6:0], 1'b0};
            end
            if (m_smp)
                next_s.rx_sr = rx_new;
            if (m_last)
            begin
                next_s.mstate = SPP_IDLE;
                next_s.data_buf = m_smp ? rx_new : s.rx_sr;
                next_s.bf = 1'b1;
                next_s.irq_flag = 1'b1;
            end
        end
        else if (s.mstate == SPP_IDLE)
            next_s.sck_out = s.clock_polarity;

        // slave shifter, runs regardless of sleep
        if (s_tx)
        begin
            next_s.txbit = s.tx_sr[7];
            next_s.tx_sr = {s.tx_sr[6:0], 1'b0};
        end
        if (s_smp)
        begin
            next_s.rx_sr = rx_new;
            next_s.bitcnt = s.bitcnt + 4'h1;
            if (s.bitcnt == 4'h7)
            begin
                next_s.bitcnt = 4'h0;
                next_s.irq_flag = 1'b1;
                if (s.bf)
                    next_s.sov = 1'b1; // old byte kept, new one lost
                else
                begin
                    next_s.data_buf = rx_new;
                    next_s.bf = 1'b1;
                end
            end
        end

        // disable or raised select aborts the byte
        if (!s.en || (s.mode == SPP_M_SLV_SS && s.ss_s2))
            next_s.bitcnt = 4'h0;
        if (!s.en)
        begin
            next_s.mstate = SPP_IDLE;
            next_s.half = 5'd0;
            next_s.div = 6'd0;
        end

        // pin drivers; output enables take effect one cycle later
        next_s.sck_oe = s.en && is_master;
        next_s.sdo_oe = s.en && !s.tx_dis && (is_master || slave_live);
        next_s.wake = next_s.irq_flag && next_s.irq_en;

        next_s.awready = !next_s.aw_full;
        next_s.wready = !next_s.w_full;
        next_s.arready = !next_s.rvalid;
    end

    // ==========================================================
    // registers; reset clears everything, which disables the port
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            s <= '0;
        else if (clk_en)
            s <= next_s;
    end

    // outputs straight from the state register
    assign s_axi_awready = s.awready;
    assign s_axi_wready = s.wready;
    assign s_axi_bvalid = s.bvalid;
    assign s_axi_bresp = s.bresp;
    assign s_axi_arready = s.arready;
    assign s_axi_rvalid = s.rvalid;
    assign s_axi_rdata = s.rdata;
    assign s_axi_rresp = s.rresp;
    assign sck_out = s.sck_out;
    assign sck_oe = s.sck_oe;
    assign sdo_out = s.txbit;
    assign sdo_oe = s.sdo_oe;
    assign wake_req = s.wake;

    // ==========================================================
    // checks
    default clocking spp_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    property p_write_collision;
        clk_en && data_wr && busy && !deliver |=> s.write_collision && $stable(s.data_buf);
    endproperty
    a_write_collision: assert property (p_write_collision) else $error("collision not flagged");

    property p_bf_clear;
        clk_en && data_rd && !deliver |=> !s.bf;
    endproperty
    a_bf_clear: assert property (p_bf_clear) else $error("buffer_full not cleared");

    property p_idle_level;
        clk_en && s.en && is_master && s.mstate == SPP_IDLE && !data_wr
            |=> s.sck_out == $past(s.clock_polarity);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("clock idle level wrong");

    property p_start;
        clk_en && data_wr && !busy && s.en && is_master |=> s.mstate == SPP_RUN;
    endproperty
    a_start: assert property (p_start) else $error("transfer did not start");

    property p_msb_first;
        clk_en && data_wr && !busy && s.cke |=> sdo_out == $past(s.wdata[7]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("first bit not msb");

    property p_ss_float;
        clk_en && s.mode == SPP_M_SLV_SS && s.ss_s2 |=> !sdo_oe;
    endproperty
    a_ss_float: assert property (p_ss_float) else $error("output driven with select high");

    property p_cnt_reset;
        clk_en && (!s.en || (s.mode == SPP_M_SLV_SS && s.ss_s2)) |=> s.bitcnt == 4'h0;
    endproperty
    a_cnt_reset: assert property (p_cnt_reset) else $error("bit counter not zeroed");

    property p_deliver;
        clk_en && m_tick && m_last |=> s.bf && s.irq_flag && s.mstate == SPP_IDLE;
    endproperty
    a_deliver: assert property (p_deliver) else $error("byte not delivered");

    property p_sleep_freeze;
        clk_en && sleep_mode && s.mstate == SPP_RUN && s.en && !wr_commit
            |=> $stable(s.half) && $stable(s.sck_out) && $stable(s.div);
    endproperty
    a_sleep_freeze: assert property (p_sleep_freeze) else $error("master moved in sleep");

    property p_sck_dir;
        clk_en && s.en && is_master |=> sck_oe;
    endproperty
    a_sck_dir: assert property (p_sck_dir) else $error("clock not driven as master");

    property p_wake;
        wake_req |-> s.irq_flag && s.irq_en;
    endproperty
    a_wake: assert property (p_wake) else $error("wake without enabled flag");

endmodule // spp_port

`default_nettype wire

// file: spp_far_end.sv
// far-side spi party: slave when the port masters, master when it is a slave
// assumes pol and cke match the port's settings before each byte
`timescale 1ns/1ns
`default_nettype none

module spp_far_end (
    input wire logic core_clk,
    input wire logic pol,
    input wire logic cke,
    input wire logic sck_out,
    input wire logic sdo_out,
    input wire logic sdo_oe,
    output var logic sdi,
    output var logic sck_in,
    output var logic ss_n
);
    logic [7:0] sr;
    logic [7:0] rx;
    logic as_slave;
    logic sdo_line;

    // a floating data line reads as the inverse of the port's current sdo_out value
    assign sdo_line = sdo_oe ? sdo_out : ~sdo_out;

    // ==========================================================
    // slave side: sample on one edge, shift on the other
    initial
    begin
        sdi = 1'b0;
        sck_in = 1'b0;
        ss_n = 1'b1;
        sr = 8'h00;
        rx = 8'h00;
        as_slave = 1'b1;
    end

    always @(sck_out)
        if (as_slave)
        begin
            if ((sck_out != pol) == cke)
                rx = {rx[6:0], sdo_line};
            else
            begin
                sdi = sr[7];
                sr = sr << 1;
            end
        end

    // cke clear: first bit appears only at the first edge, so line gets junk
    task automatic load(input logic [7:0] tx);
        rx = 8'h00;
        sr = cke ? {tx[6:0], 1'b0} : tx;
        sdi = cke ? tx[7] : ~sdi;
    endtask

    // ==========================================================
    // master side, edge select set only; idle clock stands still
    task automatic drive(input logic [7:0] tx, input int nbits);
        as_slave = 1'b0;
        rx = 8'h00;
        sck_in <= pol;
        ss_n <= 1'b0;
        sdi <= tx[7];
        repeat (8) @(posedge core_clk);
        for (int i = 0; i < nbits; i++)
        begin
            sck_in <= ~pol;
            rx = {rx[6:0], sdo_line};
            repeat (8) @(posedge core_clk);
            sck_in <= pol;
            if (i < 7)
                sdi <= tx[6 - i];
            repeat (8) @(posedge core_clk);
        end
        ss_n <= 1'b1;
        sdi <= ~sdi;
        as_slave = 1'b1;
    endtask
endmodule // spp_far_end

`default_nettype wire

// file: sync_serial_spi_port_tb.sv
// self-checking bench: axi4-lite tasks, master and slave byte exchanges
// assumes spp_far_end on the serial pins and a free-running timer tick
`timescale 1ns/1ns
`default_nettype none
`include "spp_params.svh"

`define CHK(g, e) \
    begin \
        checks_done++; \
        if ((g) !== (e)) \
        begin \
            fail_count++; \
            $display("CHECK FAILED at %0t: got %h want %h", $time, (g), (e)); \
        end \
    end

module sync_serial_spi_port_tb;
    logic core_clk, rst_n, clk_en, sleep_mode, timer_tick;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic sck_in, sck_out, sck_oe, sdi, sdo_out, sdo_oe, ss_n, wake_req, pol, cke;
    logic [7:0] tx;
    int fail_count, checks_done, cyc, n;
    int half[4] = '{2, 8, 32, 6};

    spp_port i_dut (.core_clk, .rst_n, .clk_en, .sleep_mode, .timer_tick, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_in, .sck_out, .sck_oe,
        .sdi, .sdo_out, .sdo_oe, .ss_n, .wake_req);
    spp_far_end i_far (.core_clk, .pol, .cke, .sck_out, .sdo_out, .sdo_oe, .sdi, .sck_in, .ss_n);

    // ==========================================================
    // clock, timer tick every 6 cycles, hang guard
    initial core_clk = 1'b0;
    always #4 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cyc++;
        timer_tick <= (cyc % 6 == 0);
        if (cyc == 30000)
        begin
            fail_count++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ==========================================================
    // bus tasks; both end on a falling edge so outputs have settled
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do
        begin
            @(posedge core_clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic wait_flag();
        do
            rd(`SPP_OFF_IRQC);
        while (rdat[0] !== 1'b1);
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        {rst_n, sleep_mode, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready, pol, cke, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        clk_en = 1'b1;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(`SPP_OFF_CTRL);
        `CHK(rdat, 32'h0)
        `CHK(sck_oe, 1'b0)
        rd(8'h10);
        `CHK(resp, `SPP_RESP_SLVERR)
        $display("reset and map test done");
        // each of the four spi modes paired with a different master rate
        for (int i = 0; i < 4; i++)
        begin
            pol <= i[1];
            cke <= ~i[0];
            tx = 8'hc3 ^ 8'(i << 6);
            wr(`SPP_OFF_CTRL, 32'h0);
            wr(`SPP_OFF_STAT, (32'(!i[0]) << 6) | (32'(i[1]) << 7));
            wr(`SPP_OFF_CTRL, 32'h20 | (32'(i[1]) << 4) | 32'(i));
            `CHK(sck_out, pol)
            `CHK(sck_oe, 1'b1)
            i_far.load(8'h5a ^ 8'(i));
            wr(`SPP_OFF_DATA, 32'(tx));
            if (cke)
                `CHK(sdo_out, tx[7])
            // edge-aligned wait: a timer tick may toggle the clock at once
            do
                @(posedge core_clk);
            while (sck_out === pol);
            n = 0;
            while (sck_out !== pol)
            begin
                @(posedge core_clk);
                n++;
            end
            `CHK(n, half[i])
            wait_flag();
            rd(`SPP_OFF_STAT);
            `CHK(rdat[0], 1'b1)
            `CHK(rdat[7:6], {i[1], ~i[0]})
            rd(`SPP_OFF_DATA);
            `CHK(rdat[7:0], 8'h5a ^ 8'(i))
            `CHK(i_far.rx, tx)
            rd(`SPP_OFF_STAT);
            `CHK(rdat[0], 1'b0)
            wr(`SPP_OFF_IRQC, 32'h1);
        end
        $display("mode and rate test done");
        pol <= 1'b0;
        cke <= 1'b1;
        wr(`SPP_OFF_STAT, 32'h40);
        wr(`SPP_OFF_CTRL, 32'h20);
        i_far.load(8'h00);
        wr(`SPP_OFF_DATA, 32'h11);
        wr(`SPP_OFF_DATA, 32'h22);
        rd(`SPP_OFF_CTRL);
        `CHK(rdat[7], 1'b1)
        wait_flag();
        `CHK(i_far.rx, 8'h11)
        wr(`SPP_OFF_CTRL, 32'h20);
        wr(`SPP_OFF_IRQC, 32'h7);
        $display("collision test done");
        // receive only, with wake enabled, then frozen by sleep mid-byte
        i_far.load(8'h96);
        wr(`SPP_OFF_DATA, 32'h00);
        `CHK(sdo_oe, 1'b0)
        wait_flag();
        `CHK(wake_req, 1'b1)
        wr(`SPP_OFF_IRQC, 32'h0);
        `CHK(wake_req, 1'b0)
        rd(`SPP_OFF_DATA);
        `CHK(rdat[7:0], 8'h96)
        wr(`SPP_OFF_IRQC, 32'h1);
        i_far.load(8'h3e);
        wr(`SPP_OFF_DATA, 32'h81);
        repeat (5) @(posedge core_clk);
        sleep_mode <= 1'b1;
        repeat (2) @(posedge core_clk);
        tx = {7'h0, sck_out};
        repeat (40) @(posedge core_clk);
        `CHK(sck_out, tx[0])
        sleep_mode <= 1'b0;
        wait_flag();
        rd(`SPP_OFF_DATA);
        `CHK(rdat[7:0], 8'h3e)
        `CHK(i_far.rx, 8'h81)
        wr(`SPP_OFF_CTRL, 32'h0);
        `CHK(sck_oe, 1'b0)
        $display("receive-only and sleep test done");
        // slave with select, shifting while asleep, aborted byte first
        wr(`SPP_OFF_IRQC, 32'h3);
        wr(`SPP_OFF_CTRL, 32'h24);
        `CHK(sdo_oe, 1'b0)
        sleep_mode <= 1'b1;
        wr(`SPP_OFF_DATA, 32'ha7);
        i_far.drive(8'hff, 4);
        repeat (6) @(posedge core_clk);
        `CHK(sdo_oe, 1'b0)
        rd(`SPP_OFF_IRQC);
        `CHK(rdat[0], 1'b0)
        wr(`SPP_OFF_DATA, 32'ha7);
        i_far.drive(8'h6b, 8);
        repeat (6) @(posedge core_clk);
        `CHK(wake_req, 1'b1)
        rd(`SPP_OFF_DATA);
        `CHK(rdat[7:0], 8'h6b)
        `CHK(i_far.rx, 8'ha7)
        sleep_mode <= 1'b0;
        $display("slave test done");
        end_of_test();
    end
endmodule // sync_serial_spi_port_tb

`default_nettype wire
